// >>> logic/idsc_cfg.svh
`ifndef IDSC_CFG_SVH
`define IDSC_CFG_SVH
// register byte offsets
`define IDSC_OFS_CTRL 8'h00
`define IDSC_OFS_KEY 8'h04
`define IDSC_OFS_WAKE 8'h08
`define IDSC_OFS_CFG 8'h0C
`define IDSC_OFS_CTXA 8'h10
`define IDSC_OFS_CTXB 8'h14
`define IDSC_OFS_PMC 8'h18
`define IDSC_OFS_STAT 8'h1C
`define IDSC_OFS_IRQST 8'h20
`define IDSC_OFS_IRQMSK 8'h24
// field positions
`define IDSC_DEEP_SLEEP_ENABLE_BIT_BIT 15
`define IDSC_RELEASE_BIT 0
`define IDSC_DEEP_SLEEP_BROWNOUT_EN_BIT 6
`define IDSC_DEEP_SLEEP_WATCHDOG_EN_BIT 7
`define IDSC_WDT_EN_BIT 0
`define IDSC_FAIL_SAFE_CLOCK_MONITOR_EN_BIT 1
`define IDSC_PDIS_LSB 8
// wake flag positions
`define IDSC_WK_POR 0
`define IDSC_WK_MASTER_CLEAR_PIN 1
`define IDSC_WK_ALARM 2
`define IDSC_WK_INT0 3
`define IDSC_WK_DEEP_SLEEP_WATCHDOG 4
`define IDSC_WK_ULP 5
`define IDSC_WK_DEEP_SLEEP_BROWNOUT 6
`define IDSC_WK_W 7
// interrupt status positions
`define IDSC_IRQ_IDLEWAKE 0
`define IDSC_IRQ_DEEPWAKE 1
`define IDSC_IRQ_KEYFAULT 2
`define IDSC_IRQ_W 3
// unlock keys and reset values
`define IDSC_KEY_FIRST 8'h55
`define IDSC_KEY_SECOND 8'hAA
`define IDSC_RST_CFG 16'h0000
`define IDSC_RST_PMC 16'h0000
`define IDSC_DEEP_SLEEP_WATCHDOG_CYCLES 32'd4096
`endif

// >>> logic/idsc_pkg.sv
`default_nettype none
package idsc_pkg;
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_IDLE = 2'b01,
      ST_SLEEP = 2'b10,
      ST_DEEP = 2'b11
   } idsc_state_e;
   typedef enum logic [1:0] {
      KEY_NONE = 2'b00,
      KEY_FIRST = 2'b01,
      KEY_OPEN = 2'b10
   } idsc_key_e;
endpackage : idsc_pkg
`default_nettype wire

// >>> logic/idsc_power_ctl.sv
`include "idsc_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module idsc_power_ctl #(
   parameter int unsigned DEEP_SLEEP_WATCHDOG_CYCLES = `IDSC_DEEP_SLEEP_WATCHDOG_CYCLES,
   parameter int unsigned NPERIPH = 8
) (
   input wire logic clk, // system clock
   input wire logic reset, // sync, active high
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   output logic [31:0] prdata, // apb read data
   input wire logic pwrSaveReq, // power-save instruction done
   input wire logic pwrSaveSleep, // 1 sleep operand, 0 idle
   input wire logic irqPending, // enabled interrupt pending
   input wire logic wdtTimeout, // ordinary watchdog time-out
   input wire logic porPin, // power-on event, async
   input wire logic mclrPin, // master clear, async
   input wire logic alarmPin, // calendar alarm, async
   input wire logic extInt0Pin, // external interrupt 0, async
   input wire logic ulpWakePin, // ultra low power wake, async
   input wire logic dsBrownPin, // deep brown-out detect, async
   output logic cpuHalt, // cpu stops fetching
   output logic cpuClkEn, // cpu clock gate
   output logic sysClkEn, // system clock source on
   output logic [NPERIPH-1:0] periphClkEn, // peripheral clock gates
   output logic wdtClear, // one-cycle watchdog clear
   output logic lprcRun, // low-power rc oscillator on
   output logic calClkEn, // calendar clock gate
   output logic deepActive, // deep sleep in force
   output logic ioHold, // pins held after deep wake
   output logic irq // level interrupt
);
   // =====================================================
   // checks
   initial begin
      if (NPERIPH < 1 || NPERIPH > 8) begin
         $error("NPERIPH must be 1..8");
      end
      if (DEEP_SLEEP_WATCHDOG_CYCLES < 2) begin
         $error("DEEP_SLEEP_WATCHDOG_CYCLES must be at least 2");
      end
   end

   // =====================================================
   // pin synchronisers
   localparam int WK = `IDSC_WK_W;
   logic [5:0] pinS1_q, pinS2_q;
   always_ff @(posedge clk) begin
      pinS1_q <= {dsBrownPin, ulpWakePin, extInt0Pin, alarmPin, mclrPin, porPin};
      pinS2_q <= pinS1_q;
   end

   // =====================================================
   // state
   idsc_pkg::idsc_state_e state_q, state_d;
   idsc_pkg::idsc_key_e key_q, key_d;
   logic deep_sleep_enable_bit_q, deep_sleep_enable_bit_d;
   logic release_q, release_d;
   logic [WK-1:0] wake_q, wake_d;
   logic [15:0] cfg_q, cfg_d;
   logic [15:0] ctxA_q, ctxA_d;
   logic [15:0] ctxB_q, ctxB_d;
   logic [15:0] pmc_q, pmc_d;
   logic [`IDSC_IRQ_W-1:0] irqSt_q, irqSt_d;
   logic [`IDSC_IRQ_W-1:0] irqMsk_q, irqMsk_d;
   logic [31:0] deep_sleep_watchdog_q, deep_sleep_watchdog_d;
   logic irqHeld_q, irqHeld_d;
   logic wdtClr_q, wdtClr_d;
   logic [31:0] rdata_q, rdata_d;

   logic wrEn, rdSetup, mapped, dsWdtTo, dsBorHit;
   logic [WK-1:0] wakeEv;
   logic [31:0] rdMux;
   logic [`IDSC_IRQ_W-1:0] irqEv;

   function automatic logic isMapped(input logic [7:0] a);
      isMapped = (a == `IDSC_OFS_CTRL) || (a == `IDSC_OFS_KEY) ||
         (a == `IDSC_OFS_WAKE) || (a == `IDSC_OFS_CFG) ||
         (a == `IDSC_OFS_CTXA) || (a == `IDSC_OFS_CTXB) ||
         (a == `IDSC_OFS_PMC) || (a == `IDSC_OFS_STAT) ||
         (a == `IDSC_OFS_IRQST) || (a == `IDSC_OFS_IRQMSK);
   endfunction : isMapped

   // =====================================================
   // bus decode
   assign mapped = isMapped(paddr);
   assign wrEn = psel && penable && pwrite && mapped;
   assign rdSetup = psel && !penable && !pwrite;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = rdata_q;

   // deep watchdog and brown-out own their logic, apart from wdtTimeout
   assign dsWdtTo = cfg_q[`IDSC_DEEP_SLEEP_WATCHDOG_EN_BIT] && (deep_sleep_watchdog_q == DEEP_SLEEP_WATCHDOG_CYCLES - 1);
   assign dsBorHit = cfg_q[`IDSC_DEEP_SLEEP_BROWNOUT_EN_BIT] && pinS2_q[5];

   always_comb begin
      wakeEv = '0;
      wakeEv[`IDSC_WK_POR] = pinS2_q[0];
      wakeEv[`IDSC_WK_MASTER_CLEAR_PIN] = pinS2_q[1];
      wakeEv[`IDSC_WK_ALARM] = pinS2_q[2];
      wakeEv[`IDSC_WK_INT0] = pinS2_q[3];
      wakeEv[`IDSC_WK_DEEP_SLEEP_WATCHDOG] = dsWdtTo;
      wakeEv[`IDSC_WK_ULP] = pinS2_q[4];
      wakeEv[`IDSC_WK_DEEP_SLEEP_BROWNOUT] = dsBorHit;
   end

   always_comb begin
      rdMux = 32'h0000_0000;
      unique case (paddr)
         `IDSC_OFS_CTRL: begin
            rdMux[`IDSC_DEEP_SLEEP_ENABLE_BIT_BIT] = deep_sleep_enable_bit_q;
            rdMux[`IDSC_RELEASE_BIT] = release_q;
         end
         `IDSC_OFS_WAKE: rdMux[WK-1:0] = wake_q;
         `IDSC_OFS_CFG: rdMux[15:0] = cfg_q;
         `IDSC_OFS_CTXA: rdMux[15:0] = ctxA_q;
         `IDSC_OFS_CTXB: rdMux[15:0] = ctxB_q;
         `IDSC_OFS_PMC: rdMux[15:0] = pmc_q;
         `IDSC_OFS_STAT: rdMux[1:0] = state_q;
         `IDSC_OFS_IRQST: rdMux[`IDSC_IRQ_W-1:0] = irqSt_q;
         `IDSC_OFS_IRQMSK: rdMux[`IDSC_IRQ_W-1:0] = irqMsk_q;
         default: rdMux = 32'h0000_0000;
      endcase
   end

   // =====================================================
   // next state
   always_comb begin
      state_d = state_q;
      key_d = key_q;
      deep_sleep_enable_bit_d = deep_sleep_enable_bit_q;
      release_d = release_q;
      wake_d = wake_q;
      cfg_d = cfg_q;
      ctxA_d = ctxA_q;
      ctxB_d = ctxB_q;
      pmc_d = pmc_q;
      irqMsk_d = irqMsk_q;
      irqEv = '0;
      deep_sleep_watchdog_d = 32'h0000_0000;
      irqHeld_d = irqHeld_q;
      wdtClr_d = 1'b0;
      rdata_d = rdSetup ? rdMux : rdata_q;

      // register writes; the key only opens for the very next write
      if (wrEn) begin
         if (key_q != idsc_pkg::KEY_NONE) begin
            key_d = idsc_pkg::KEY_NONE;
         end
         unique case (paddr)
            `IDSC_OFS_CTRL: begin
               release_d = pwdata[`IDSC_RELEASE_BIT] & release_q;
               if (!pwdata[`IDSC_DEEP_SLEEP_ENABLE_BIT_BIT]) begin
                  deep_sleep_enable_bit_d = 1'b0;
               end else if (key_q == idsc_pkg::KEY_OPEN) begin
                  deep_sleep_enable_bit_d = 1'b1;
               end else if (!deep_sleep_enable_bit_q) begin
                  irqEv[`IDSC_IRQ_KEYFAULT] = 1'b1;
               end
            end
            `IDSC_OFS_KEY: begin
               if (pwdata[7:0] == `IDSC_KEY_FIRST) begin
                  key_d = idsc_pkg::KEY_FIRST;
               end else if (pwdata[7:0] == `IDSC_KEY_SECOND && key_q == idsc_pkg::KEY_FIRST) begin
                  key_d = idsc_pkg::KEY_OPEN;
               end
            end
            `IDSC_OFS_CFG: cfg_d = pwdata[15:0];
            `IDSC_OFS_CTXA: ctxA_d = pwdata[15:0];
            `IDSC_OFS_CTXB: ctxB_d = pwdata[15:0];
            `IDSC_OFS_PMC: pmc_d = pwdata[15:0];
            `IDSC_OFS_IRQMSK: irqMsk_d = pwdata[`IDSC_IRQ_W-1:0];
            default: begin
            end
         endcase
      end
      // flags clear whenever the enable bit goes from 0 to 1
      if (deep_sleep_enable_bit_d && !deep_sleep_enable_bit_q) begin
         wake_d = '0;
      end

      // deep_sleep_enable_bit stays set until a deep wake or a write of 0; no watch on it
      unique case (state_q)
         idsc_pkg::ST_RUN: begin
            if (pwrSaveReq) begin
               irqHeld_d = irqPending;
               if (!pwrSaveSleep) begin
                  state_d = idsc_pkg::ST_IDLE;
                  wdtClr_d = 1'b1;
               end else if (deep_sleep_enable_bit_q) begin
                  state_d = idsc_pkg::ST_DEEP;
               end else begin
                  state_d = idsc_pkg::ST_SLEEP;
               end
            end
         end
         idsc_pkg::ST_IDLE, idsc_pkg::ST_SLEEP: begin
            if (irqPending || irqHeld_q || wdtTimeout) begin
               state_d = idsc_pkg::ST_RUN;
               irqHeld_d = 1'b0;
               irqEv[`IDSC_IRQ_IDLEWAKE] = 1'b1;
            end
         end
         idsc_pkg::ST_DEEP: begin
            irqHeld_d = 1'b0;
            if (cfg_q[`IDSC_DEEP_SLEEP_WATCHDOG_EN_BIT] && !dsWdtTo) begin
               deep_sleep_watchdog_d = deep_sleep_watchdog_q + 32'h0000_0001;
            end
            if (|wakeEv) begin
               state_d = idsc_pkg::ST_RUN;
               deep_sleep_enable_bit_d = 1'b0;
               release_d = 1'b1;
               wake_d = wake_q | wakeEv;
               irqEv[`IDSC_IRQ_DEEPWAKE] = 1'b1;
            end
         end
      endcase

      // status set wins over a same-cycle write-one clear
      irqSt_d = irqSt_q;
      if (wrEn && paddr == `IDSC_OFS_IRQST) begin
         irqSt_d = irqSt_q & ~pwdata[`IDSC_IRQ_W-1:0];
      end
      irqSt_d = irqSt_d | irqEv;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_q <= idsc_pkg::ST_RUN;
         key_q <= idsc_pkg::KEY_NONE;
         deep_sleep_enable_bit_q <= 1'b0;
         release_q <= 1'b0;
         wake_q <= '0;
         cfg_q <= `IDSC_RST_CFG;
         ctxA_q <= 16'h0000;
         ctxB_q <= 16'h0000;
         pmc_q <= `IDSC_RST_PMC;
         irqSt_q <= '0;
         irqMsk_q <= '0;
         deep_sleep_watchdog_q <= 32'h0000_0000;
         irqHeld_q <= 1'b0;
         wdtClr_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else begin
         state_q <= state_d;
         key_q <= key_d;
         deep_sleep_enable_bit_q <= deep_sleep_enable_bit_d;
         release_q <= release_d;
         wake_q <= wake_d;
         cfg_q <= cfg_d;
         ctxA_q <= ctxA_d;
         ctxB_q <= ctxB_d;
         pmc_q <= pmc_d;
         irqSt_q <= irqSt_d;
         irqMsk_q <= irqMsk_d;
         deep_sleep_watchdog_q <= deep_sleep_watchdog_d;
         irqHeld_q <= irqHeld_d;
         wdtClr_q <= wdtClr_d;
         rdata_q <= rdata_d;
      end
   end

   // =====================================================
   // power outputs, all decoded from registered state
   logic isRun, isIdle, isDeep;
   assign isRun = (state_q == idsc_pkg::ST_RUN);
   assign isIdle = (state_q == idsc_pkg::ST_IDLE);
   assign isDeep = (state_q == idsc_pkg::ST_DEEP);
   assign cpuHalt = !isRun;
   assign cpuClkEn = isRun;
   assign sysClkEn = isRun || isIdle;
   assign periphClkEn = isRun ? '1 : (isIdle ? ~pmc_q[`IDSC_PDIS_LSB +: NPERIPH] : '0);
   assign wdtClear = wdtClr_q;
   // wdt/fail_safe_clock_monitor want the rc in idle; deep watchdog wants it in deep
   assign lprcRun = isRun || (isIdle && (pmc_q[`IDSC_WDT_EN_BIT] || pmc_q[`IDSC_FAIL_SAFE_CLOCK_MONITOR_EN_BIT])) ||
      (isDeep && cfg_q[`IDSC_DEEP_SLEEP_WATCHDOG_EN_BIT]);
   assign calClkEn = 1'b1;
   assign deepActive = isDeep;
   assign ioHold = release_q;
   assign irq = |(irqSt_q & irqMsk_q);

   // =====================================================
   // assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_enter_idle;
      isRun && pwrSaveReq && !pwrSaveSleep;
   endsequence
   sequence s_idle_then_run;
      isIdle ##1 isRun;
   endsequence

   a_halt_when_saving: assert property (!isRun |-> cpuHalt && !cpuClkEn)
      else $error("cpu not halted in power save");
   a_wdt_clear_entry: assert property (s_enter_idle |=> isIdle && wdtClear)
      else $error("watchdog not cleared on idle entry");
   a_idle_sysclk: assert property (isIdle |-> sysClkEn)
      else $error("system clock stopped in idle");
   a_low_power_rc_osc_in_idle: assert property (isIdle && pmc_q[`IDSC_WDT_EN_BIT] |-> lprcRun)
      else $error("rc oscillator off in idle");
   a_idle_wake_time: assert property (isIdle && wdtTimeout |=> isRun && cpuClkEn)
      else $error("idle did not end on time-out");
   a_coincident_irq: assert property (s_enter_idle and irqPending |=> s_idle_then_run)
      else $error("coincident interrupt lost");
   a_deep_exit: assert property (isDeep && pinS2_q[3] |=> isRun && !deep_sleep_enable_bit_q)
      else $error("deep sleep exit wrong");
   a_cal_running: assert property (isDeep |-> calClkEn)
      else $error("calendar clock stopped");
   a_deep_sleep_enable_bit_unlocked: assert property ($rose(deep_sleep_enable_bit_q) |-> $past(key_q) == idsc_pkg::KEY_OPEN)
      else $error("enable bit set without unlock");
   a_flags_cleared: assert property ($rose(deep_sleep_enable_bit_q) |-> wake_q == '0)
      else $error("wake flags not cleared");
   a_bor_gated: assert property (isDeep && !cfg_q[`IDSC_DEEP_SLEEP_BROWNOUT_EN_BIT] && wakeEv[5:0] == '0 |=> isDeep)
      else $error("brown-out acted while disabled");
endmodule : idsc_power_ctl
`default_nettype wire

// >>> verification/idsc_tb.sv
`include "idsc_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, x) begin checkCount++; if ((g) !== (x)) begin fails++; \
   $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, x); end end
module testbench;
   typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} idsc_row_s;
   typedef struct {logic [31:0] cfg; logic [6:0] pins; logic [31:0] wake;} idsc_deep_s;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic pwrSaveReq = 1'b0;
   logic pwrSaveSleep = 1'b0;
   logic irqPending = 1'b0;
   logic wdtTimeout = 1'b0;
   logic [6:0] pins = 7'h00;
   logic pready, pslverr, cpuHalt, cpuClkEn, sysClkEn, wdtClear, lprcRun, calClkEn, deepActive, ioHold, irq, er;
   logic [31:0] prdata, rd;
   logic [7:0] periphClkEn;
   int fails = 0;
   int checkCount = 0;
   int n;
   // ==========================================
   // stimulus tables
   idsc_row_s rows [0:25] = '{
      '{1'b0, `IDSC_OFS_CTRL, 32'h0, 32'h0, 1'b0}, '{1'b0, `IDSC_OFS_CFG, 32'h0, 32'h0, 1'b0},
      '{1'b0, `IDSC_OFS_PMC, 32'h0, 32'h0, 1'b0}, '{1'b0, `IDSC_OFS_IRQST, 32'h0, 32'h0, 1'b0},
      '{1'b1, `IDSC_OFS_CTXA, 32'hFFFFA5C3, 32'h0, 1'b0}, '{1'b0, `IDSC_OFS_CTXA, 32'h0, 32'h0000A5C3, 1'b0},
      '{1'b1, `IDSC_OFS_CTXB, 32'h12345A3C, 32'h0, 1'b0}, '{1'b0, `IDSC_OFS_CTXB, 32'h0, 32'h00005A3C, 1'b0},
      '{1'b1, `IDSC_OFS_CFG, 32'h000000FF, 32'h0, 1'b0}, '{1'b0, `IDSC_OFS_CFG, 32'h0, 32'h000000FF, 1'b0},
      '{1'b1, `IDSC_OFS_PMC, 32'h0000FFFF, 32'h0, 1'b0}, '{1'b0, `IDSC_OFS_PMC, 32'h0, 32'h0000FFFF, 1'b0},
      '{1'b1, `IDSC_OFS_PMC, 32'h00000F03, 32'h0, 1'b0}, '{1'b0, 8'h28, 32'h0, 32'h0, 1'b1},
      '{1'b1, 8'h28, 32'h1, 32'h0, 1'b1}, '{1'b1, `IDSC_OFS_KEY, 32'h55, 32'h0, 1'b0},
      '{1'b1, `IDSC_OFS_CTXA, 32'h1, 32'h0, 1'b0}, '{1'b1, `IDSC_OFS_KEY, 32'hAA, 32'h0, 1'b0},
      '{1'b1, `IDSC_OFS_CTRL, 32'h8000, 32'h0, 1'b0}, '{1'b0, `IDSC_OFS_CTRL, 32'h0, 32'h0, 1'b0},
      '{1'b0, `IDSC_OFS_IRQST, 32'h0, 32'h4, 1'b0}, '{1'b1, `IDSC_OFS_IRQMSK, 32'h7, 32'h0, 1'b0},
      '{1'b0, `IDSC_OFS_IRQMSK, 32'h0, 32'h7, 1'b0}, '{1'b1, `IDSC_OFS_IRQST, 32'h4, 32'h0, 1'b0},
      '{1'b0, `IDSC_OFS_IRQST, 32'h0, 32'h0, 1'b0}, '{1'b0, `IDSC_OFS_STAT, 32'h0, 32'h0, 1'b0}};
   // last row: brown-out with its enable off must not wake, clear pin does
   idsc_deep_s deep [0:7] = '{'{32'h0, 7'h01, 32'h01}, '{32'h0, 7'h02, 32'h02}, '{32'h0, 7'h04, 32'h04},
      '{32'h0, 7'h08, 32'h08}, '{32'h80, 7'h00, 32'h10}, '{32'h0, 7'h20, 32'h20}, '{32'h40, 7'h40, 32'h40},
      '{32'h0, 7'h42, 32'h02}};
   always #4 clk = ~clk;
   idsc_power_ctl #(.DEEP_SLEEP_WATCHDOG_CYCLES(8), .NPERIPH(8)) dut (.clk(clk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
      .prdata(prdata), .pwrSaveReq(pwrSaveReq), .pwrSaveSleep(pwrSaveSleep), .irqPending(irqPending),
      .wdtTimeout(wdtTimeout), .porPin(pins[0]), .mclrPin(pins[1]), .alarmPin(pins[2]), .extInt0Pin(pins[3]),
      .ulpWakePin(pins[5]), .dsBrownPin(pins[6]), .cpuHalt(cpuHalt), .cpuClkEn(cpuClkEn), .sysClkEn(sysClkEn),
      .periphClkEn(periphClkEn), .wdtClear(wdtClear), .lprcRun(lprcRun), .calClkEn(calClkEn),
      .deepActive(deepActive), .ioHold(ioHold), .irq(irq));
   // ==========================================
   // bus and control tasks
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task rdchk(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      `CHK(rd, x)
   endtask : rdchk
   task pulse_save(input logic sl, input logic ip);
      @(posedge clk);
      pwrSaveReq <= 1'b1;
      pwrSaveSleep <= sl;
      irqPending <= ip;
      @(posedge clk);
      pwrSaveReq <= 1'b0;
      irqPending <= 1'b0;
      #1;
   endtask : pulse_save
   task end_sim;
      $display("checks %0d mismatches %0d", checkCount, fails);
      if (fails == 0 && checkCount > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_sim
   // generous: the whole sequence needs well under 2000 cycles
   initial begin
      #100000;
      fails++;
      end_sim();
   end
   // ==========================================
   // main sequence
   initial begin
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      #1;
      `CHK({cpuHalt, cpuClkEn, sysClkEn, wdtClear, lprcRun, deepActive, ioHold, irq}, 8'h68)
      `CHK(periphClkEn, 8'hFF)
      `CHK(pready, 1'b1)
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         `CHK(er, rows[i].e)
         if (!rows[i].w) `CHK(rd, rows[i].x)
      end
      // idle: woken by interrupt, then by watchdog time-out
      for (int s = 0; s < 2; s++) begin
         pulse_save(1'b0, 1'b0);
         `CHK({cpuHalt, cpuClkEn}, 2'h2)
         `CHK(wdtClear, 1'b1)
         `CHK({sysClkEn, periphClkEn}, 9'h1F0)
         `CHK(lprcRun, 1'b1)
         @(posedge clk);
         #1;
         `CHK({cpuHalt, wdtClear}, 2'h2)
         @(posedge clk);
         irqPending <= (s == 0);
         wdtTimeout <= (s == 1);
         @(posedge clk);
         irqPending <= 1'b0;
         wdtTimeout <= 1'b0;
         #1;
         `CHK({cpuHalt, cpuClkEn, periphClkEn}, 10'h1FF)
      end
      rdchk(`IDSC_OFS_IRQST, 32'h1);
      `CHK(irq, 1'b1)
      apb(1'b1, `IDSC_OFS_IRQST, 32'h1);
      #1;
      `CHK(irq, 1'b0)
      pulse_save(1'b0, 1'b1);
      `CHK(cpuHalt, 1'b1)
      @(posedge clk);
      #1;
      `CHK(cpuHalt, 1'b0)
      // plain sleep with the enable bit clear: system clock off, ordinary watchdog wakes it
      pulse_save(1'b1, 1'b0);
      `CHK({deepActive, cpuHalt, sysClkEn}, 3'h2)
      @(posedge clk);
      wdtTimeout <= 1'b1;
      @(posedge clk);
      wdtTimeout <= 1'b0;
      #1;
      `CHK(cpuHalt, 1'b0)
      apb(1'b1, `IDSC_OFS_IRQST, 32'h1);
      foreach (deep[i]) begin
         apb(1'b1, `IDSC_OFS_CFG, deep[i].cfg);
         apb(1'b1, `IDSC_OFS_KEY, 32'h55);
         apb(1'b1, `IDSC_OFS_KEY, 32'hAA);
         apb(1'b1, `IDSC_OFS_CTRL, 32'h8000);
         rdchk(`IDSC_OFS_CTRL, 32'h8000);
         rdchk(`IDSC_OFS_WAKE, 32'h0);
         repeat (40) @(posedge clk);
         pulse_save(1'b1, 1'b0);
         `CHK({deepActive, cpuHalt, periphClkEn}, 10'h300)
         `CHK(lprcRun, deep[i].cfg[7])
         `CHK(calClkEn, 1'b1)
         // ordinary watchdog must not end deep sleep
         @(posedge clk);
         wdtTimeout <= 1'b1;
         @(posedge clk);
         wdtTimeout <= 1'b0;
         #1;
         `CHK(deepActive, 1'b1)
         @(posedge clk);
         pins <= deep[i].pins;
         for (n = 0; n < 30 && cpuHalt !== 1'b0; n++) begin
            @(posedge clk);
            #1;
         end
         `CHK({deepActive, ioHold}, 2'h1)
         @(posedge clk);
         pins <= 7'h00;
         rdchk(`IDSC_OFS_CTRL, 32'h1);
         rdchk(`IDSC_OFS_WAKE, deep[i].wake);
         rdchk(`IDSC_OFS_IRQST, 32'h2);
         apb(1'b1, `IDSC_OFS_IRQST, 32'h2);
         apb(1'b1, `IDSC_OFS_CTRL, 32'h0);
         #1;
         `CHK({ioHold, irq}, 2'h0)
         repeat (3) @(posedge clk);
      end
      // a reset arriving in idle must wake the core
      pulse_save(1'b0, 1'b0);
      @(posedge clk);
      reset <= 1'b1;
      @(posedge clk);
      reset <= 1'b0;
      #1;
      `CHK(cpuHalt, 1'b0)
      end_sim();
   end
endmodule : testbench
`default_nettype wire
